// >>> rtl/rbsc_params.svh
`ifndef RBSC_PARAMS_SVH
`define RBSC_PARAMS_SVH
`define RBSC_CLK_MHZ 20
`define RBSC_TX_DELAY_US 16
`define RBSC_WAKE_COLD_US 240
`define RBSC_WAKE_WARM_US 25
`define RBSC_ADR_STATUS 8'h00
`define RBSC_ADR_COMMAND 8'h04
`define RBSC_ADR_PIN 8'h08
`define RBSC_ADR_CHANNEL 8'h0C
`define RBSC_ADR_RSSI 8'h10
`define RBSC_ADR_MASK 8'h14
`define RBSC_ADR_FLAGS 8'h18
`define RBSC_ST_BUSY_RX 5'h01
`define RBSC_ST_BUSY_TX 5'h02
`define RBSC_ST_LISTEN 5'h06
`define RBSC_ST_CLK_IDLE 5'h08
`define RBSC_ST_SYNTH_RDY 5'h09
`define RBSC_ST_SLEEP 5'h0F
`define RBSC_ST_PENDING 5'h1F
`define RBSC_CMD_NOP 5'h00
`define RBSC_CMD_TX_GO 5'h02
`define RBSC_CMD_IDLE 5'h08
`define RBSC_CMD_LISTEN 5'h06
`define RBSC_CMD_SYNTH 5'h09
`define RBSC_CHAN_RST 5'h0B
`define RBSC_BIT_TRIG 0
`define RBSC_BIT_RRST 1
`define RBSC_BIT_FCS 7
`define RBSC_IRQ_LOCK 0
`define RBSC_IRQ_HDR 2
`define RBSC_IRQ_RXD 3
`define RBSC_IRQ_AMI 5
`define RBSC_IRQ_TXD 6
`define RBSC_IRQ_WAKE 7
`endif

// >>> rtl/rbsc_pkg.sv
package rbsc_pkg;
    typedef enum logic [3:0] {
        RBSC_SLEEP, RBSC_WAKE, RBSC_IDLE, RBSC_REG_UP, RBSC_SYN_UP,
        RBSC_READY, RBSC_LISTEN, RBSC_RX, RBSC_TX_WAIT, RBSC_TX
    } rbsc_state_t;
endpackage

// >>> rtl/rbsc_top.sv
`timescale 1ns/100ps
`include "rbsc_params.svh"
module rbsc_top #(
    parameter int WAKE_COLD_CYC = `RBSC_WAKE_COLD_US * `RBSC_CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    input wire logic adc_reg_on_i,
    input wire logic reg_settled_i,
    input wire logic synth_locked_i,
    input wire logic xosc_running_i,
    input wire logic global_irq_en_i,
    input wire logic sync_hdr_i,
    input wire logic phy_hdr_ok_i,
    input wire logic [6:0] frame_len_i,
    input wire logic rx_byte_vld_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic mhr_done_i,
    input wire logic addr_match_i,
    input wire logic rx_end_i,
    input wire logic fcs_ok_i,
    input wire logic tx_end_i,
    output logic reg_en_o,
    output logic synth_en_o,
    output logic synth_tx_o,
    output logic rx_en_o,
    output logic pa_en_o,
    output logic tx_start_o,
    output logic xosc_en_o,
    output logic ftune_o,
    output logic [4:0] channel_o,
    output logic fb_we_o,
    output logic [6:0] fb_addr_o,
    output logic [7:0] fb_data_o,
    output logic irq_o
);
    localparam int TXD_CYC = `RBSC_TX_DELAY_US * `RBSC_CLK_MHZ;
    localparam int WARM_CYC = `RBSC_WAKE_WARM_US * `RBSC_CLK_MHZ;
    initial begin
        if (WAKE_COLD_CYC < 2 || WAKE_COLD_CYC > 65535)
            $error("WAKE_COLD_CYC out of range");
    end

    // two-flop synchronisers for analog status inputs
    logic [3:0] sync1, sync2;
    always_ff @(posedge clk_i) begin
        sync1 <= {xosc_running_i, synth_locked_i, reg_settled_i,
                  adc_reg_on_i};
        sync2 <= sync1;
    end
    wire adc_on = sync2[0];
    wire reg_ok = sync2[1];
    wire locked = sync2[2];
    wire xosc_on = sync2[3];

    rbsc_pkg::rbsc_state_t state, next_state;
    logic [15:0] cnt, next_cnt;
    logic [4:0] chan, next_chan;
    logic trig, next_trig, trig_d;
    logic rrst, next_rrst;
    logic [7:0] mask, next_mask, flags, next_flags, rssi, next_rssi;
    logic [6:0] fbp, next_fbp;
    logic lock_seen, next_lock_seen;
    logic ack, next_ack;
    logic [31:0] rdat, next_rdat;
    logic [7:0] ev;
    logic irq;

    wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    wire rd_acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [4:0] cmd = (wr && wb_adr_i == `RBSC_ADR_COMMAND) ?
                     wb_dat_i[4:0] : `RBSC_CMD_NOP;
    wire trig_rise = trig & ~trig_d;
    wire trig_fall = ~trig & trig_d;
    wire soft_rst = rrst;

    // status code for a state; transitional states report pending
    function automatic logic [4:0] stat_code(rbsc_pkg::rbsc_state_t s);
        case (s)
            rbsc_pkg::RBSC_SLEEP: stat_code = `RBSC_ST_SLEEP;
            rbsc_pkg::RBSC_IDLE: stat_code = `RBSC_ST_CLK_IDLE;
            rbsc_pkg::RBSC_READY: stat_code = `RBSC_ST_SYNTH_RDY;
            rbsc_pkg::RBSC_LISTEN: stat_code = `RBSC_ST_LISTEN;
            rbsc_pkg::RBSC_RX: stat_code = `RBSC_ST_BUSY_RX;
            rbsc_pkg::RBSC_TX: stat_code = `RBSC_ST_BUSY_TX;
            default: stat_code = `RBSC_ST_PENDING;
        endcase
    endfunction

    // state machine and event generation
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_fbp = fbp;
        next_lock_seen = lock_seen;
        ev = 8'h00;
        case (state)
            rbsc_pkg::RBSC_SLEEP: begin
                if (trig_fall) begin
                    next_state = rbsc_pkg::RBSC_WAKE;
                    next_cnt = xosc_on ? 16'(WARM_CYC)
                                       : 16'(WAKE_COLD_CYC);
                end
            end
            rbsc_pkg::RBSC_WAKE: begin
                next_cnt = cnt - 16'h0001;
                if (cnt == 16'h0001) begin
                    next_state = rbsc_pkg::RBSC_IDLE;
                    ev[`RBSC_IRQ_WAKE] = 1'b1;
                end
            end
            rbsc_pkg::RBSC_IDLE: begin
                if (trig_rise)
                    next_state = rbsc_pkg::RBSC_SLEEP;
                else if (cmd == `RBSC_CMD_LISTEN)
                    next_state = rbsc_pkg::RBSC_LISTEN;
                else if (cmd == `RBSC_CMD_SYNTH)
                    next_state = rbsc_pkg::RBSC_REG_UP;
            end
            rbsc_pkg::RBSC_REG_UP: begin
                if (reg_ok || adc_on)
                    next_state = rbsc_pkg::RBSC_SYN_UP;
            end
            rbsc_pkg::RBSC_SYN_UP: begin
                if (locked)
                    next_state = rbsc_pkg::RBSC_READY;
            end
            rbsc_pkg::RBSC_READY: begin
                if (trig_rise || cmd == `RBSC_CMD_TX_GO) begin
                    next_state = rbsc_pkg::RBSC_TX_WAIT;
                    next_cnt = 16'(TXD_CYC);
                end else if (cmd == `RBSC_CMD_LISTEN)
                    next_state = rbsc_pkg::RBSC_LISTEN;
                else if (cmd == `RBSC_CMD_IDLE)
                    next_state = rbsc_pkg::RBSC_IDLE;
            end
            rbsc_pkg::RBSC_LISTEN: begin
                if (cmd == `RBSC_CMD_IDLE)
                    next_state = rbsc_pkg::RBSC_IDLE;
                else if (cmd == `RBSC_CMD_SYNTH)
                    next_state = rbsc_pkg::RBSC_READY;
                else if (sync_hdr_i && lock_seen) begin
                    next_state = rbsc_pkg::RBSC_RX;
                    next_fbp = 7'h00;
                end
            end
            rbsc_pkg::RBSC_RX: begin
                if (phy_hdr_ok_i)
                    ev[`RBSC_IRQ_HDR] = 1'b1;
                if (rx_byte_vld_i)
                    next_fbp = fbp + 7'h01;
                if (mhr_done_i && addr_match_i)
                    ev[`RBSC_IRQ_AMI] = 1'b1;
                if (rx_end_i) begin
                    ev[`RBSC_IRQ_RXD] = 1'b1;
                    next_state = rbsc_pkg::RBSC_LISTEN;
                end
            end
            rbsc_pkg::RBSC_TX_WAIT: begin
                next_cnt = cnt - 16'h0001;
                if (cnt == 16'h0001)
                    next_state = rbsc_pkg::RBSC_TX;
            end
            rbsc_pkg::RBSC_TX: begin
                if (frame_len_i == 7'h00)
                    next_state = rbsc_pkg::RBSC_READY;
                else if (tx_end_i) begin
                    ev[`RBSC_IRQ_TXD] = 1'b1;
                    next_state = rbsc_pkg::RBSC_READY;
                end
            end
            default: next_state = rbsc_pkg::RBSC_IDLE;
        endcase
        // lock seen while synthesizer is enabled
        if (next_state == rbsc_pkg::RBSC_IDLE ||
            next_state == rbsc_pkg::RBSC_REG_UP)
            next_lock_seen = 1'b0;
        else if (locked && !lock_seen && synth_en_o) begin
            next_lock_seen = 1'b1;
            ev[`RBSC_IRQ_LOCK] = 1'b1;
        end
    end

    // register file next values
    always_comb begin
        next_trig = trig;
        next_rrst = 1'b0;
        next_chan = chan;
        next_mask = mask;
        next_rssi = rssi;
        next_flags = flags | ev; // set wins over clear
        next_ack = rd_acc;
        next_rdat = 32'h0000_0000;
        if (wr) begin
            case (wb_adr_i)
                `RBSC_ADR_PIN: begin
                    next_trig = wb_dat_i[`RBSC_BIT_TRIG];
                    next_rrst = wb_dat_i[`RBSC_BIT_RRST];
                end
                `RBSC_ADR_CHANNEL: next_chan = wb_dat_i[4:0];
                `RBSC_ADR_MASK: next_mask = wb_dat_i[7:0];
                `RBSC_ADR_FLAGS: next_flags = (flags & ~wb_dat_i[7:0]) | ev;
                default: ;
            endcase
        end
        if (ev[`RBSC_IRQ_RXD])
            next_rssi[`RBSC_BIT_FCS] = fcs_ok_i;
        case (wb_adr_i)
            `RBSC_ADR_STATUS: next_rdat = {27'h0, stat_code(state)};
            `RBSC_ADR_PIN: next_rdat = {30'h0, rrst, trig};
            `RBSC_ADR_CHANNEL: next_rdat = {27'h0, chan};
            `RBSC_ADR_RSSI: next_rdat = {24'h0, rssi};
            `RBSC_ADR_MASK: next_rdat = {24'h0, mask};
            `RBSC_ADR_FLAGS: next_rdat = {24'h0, flags};
            default: next_rdat = 32'h0000_0000;
        endcase
    end

    // registers; radio reset restores all but the pin register, trig_d and the bus ack and read data
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst) begin
            state <= rbsc_pkg::RBSC_IDLE;
            cnt <= 16'h0000;
            fbp <= 7'h00;
            lock_seen <= 1'b0;
            chan <= `RBSC_CHAN_RST;
            mask <= 8'h00;
            flags <= 8'h00;
            rssi <= 8'h00;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            fbp <= next_fbp;
            lock_seen <= next_lock_seen;
            chan <= next_chan;
            mask <= next_mask;
            flags <= next_flags;
            rssi <= next_rssi;
        end
        if (rst_i) begin
            trig <= 1'b0;
            trig_d <= 1'b0;
            rrst <= 1'b0;
            ack <= 1'b0;
            rdat <= 32'h0000_0000;
        end else begin
            trig <= next_trig;
            trig_d <= trig;
            rrst <= next_rrst;
            ack <= next_ack;
            rdat <= next_rdat;
        end
    end

    assign irq = |(flags & mask) & global_irq_en_i;

    // registered analog controls and outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_en_o <= 1'b0;
            synth_en_o <= 1'b0;
            synth_tx_o <= 1'b0;
            rx_en_o <= 1'b0;
            pa_en_o <= 1'b0;
            tx_start_o <= 1'b0;
            xosc_en_o <= 1'b1;
            ftune_o <= 1'b0;
            channel_o <= `RBSC_CHAN_RST;
            fb_we_o <= 1'b0;
            fb_addr_o <= 7'h00;
            fb_data_o <= 8'h00;
            irq_o <= 1'b0;
        end else begin
            reg_en_o <= next_state != rbsc_pkg::RBSC_SLEEP &&
                        next_state != rbsc_pkg::RBSC_WAKE &&
                        next_state != rbsc_pkg::RBSC_IDLE;
            synth_en_o <= next_state != rbsc_pkg::RBSC_SLEEP &&
                          next_state != rbsc_pkg::RBSC_WAKE &&
                          next_state != rbsc_pkg::RBSC_IDLE &&
                          next_state != rbsc_pkg::RBSC_REG_UP;
            synth_tx_o <= next_state == rbsc_pkg::RBSC_TX_WAIT ||
                          next_state == rbsc_pkg::RBSC_TX;
            rx_en_o <= next_state == rbsc_pkg::RBSC_LISTEN ||
                       next_state == rbsc_pkg::RBSC_RX;
            pa_en_o <= next_state == rbsc_pkg::RBSC_TX_WAIT ||
                       next_state == rbsc_pkg::RBSC_TX;
            tx_start_o <= state == rbsc_pkg::RBSC_TX_WAIT &&
                          next_state == rbsc_pkg::RBSC_TX;
            xosc_en_o <= next_state != rbsc_pkg::RBSC_SLEEP;
            ftune_o <= next_state == rbsc_pkg::RBSC_WAKE;
            channel_o <= chan;
            fb_we_o <= state == rbsc_pkg::RBSC_RX && rx_byte_vld_i;
            fb_addr_o <= fbp;
            fb_data_o <= rx_byte_i;
            irq_o <= irq;
        end
    end
    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;

    // assertions
    sequence tx_req_s;
        state == rbsc_pkg::RBSC_READY && next_state ==
            rbsc_pkg::RBSC_TX_WAIT;
    endsequence
    synth_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
        synth_en_o |-> reg_en_o) else $error("synth before reg");
    tx_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_req_s |=> (state == rbsc_pkg::RBSC_TX_WAIT)[*8])
        else $error("tx delay short");
    tx_only_ready_a: assert property (@(posedge clk_i) disable iff (rst_i)
        next_state == rbsc_pkg::RBSC_TX_WAIT && state !=
        rbsc_pkg::RBSC_TX_WAIT |-> state == rbsc_pkg::RBSC_READY)
        else $error("tx outside ready");
    listen_stay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == rbsc_pkg::RBSC_LISTEN && cmd == `RBSC_CMD_NOP && !rrst |=>
        state inside {rbsc_pkg::RBSC_LISTEN, rbsc_pkg::RBSC_RX})
        else $error("left listen");
    rx_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == rbsc_pkg::RBSC_RX && rx_end_i && !rrst |=>
        state == rbsc_pkg::RBSC_LISTEN && flags[`RBSC_IRQ_RXD])
        else $error("rx end lost");
    tx_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == rbsc_pkg::RBSC_TX && tx_end_i && frame_len_i != 7'h00 &&
        !rrst |=> state == rbsc_pkg::RBSC_READY ##1 !pa_en_o)
        else $error("tx end wrong");
    irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> $past(global_irq_en_i) && $past(|(flags & mask)))
        else $error("irq ungated");
    rreset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rrst |=> state == rbsc_pkg::RBSC_IDLE && mask == 8'h00)
        else $error("radio reset");
    pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev[`RBSC_IRQ_LOCK] |=> !ev[`RBSC_IRQ_LOCK])
        else $error("lock not pulse");
endmodule // rbsc_top

// >>> sim/radio_basic_state_control_tb.sv
`timescale 1ns/100ps
`include "rbsc_params.svh"
module radio_basic_state_control_tb;
    logic clk_i, rst_i, cyc, stb, we, glob, xrun, adc, rx_go, match, fcs;
    logic [7:0] adr, seed;
    logic [31:0] wdat, rdo, q;
    logic [3:0] sel;
    logic [6:0] len;
    logic [4:0] ch;
    logic [15:0] rnd;
    logic ack, rs, sl, sh, ph, bv, md, am, re, fo, te;
    logic reg_en_o, synth_en_o, synth_tx_o, rx_en_o, pa_en_o, tx_start_o;
    logic xosc_en_o, ftune_o, fb_we_o, irq_o, ftseen;
    logic [4:0] channel_o;
    logic [6:0] fb_addr_o;
    logic [7:0] fb_data_o, rb;
    int bad_count = 0;
    int n_checks = 0;
    int fb_n, t;
    realtime t0;
    rbsc_top #(.WAKE_COLD_CYC(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_ack_o(ack),
        .adc_reg_on_i(adc), .reg_settled_i(rs), .synth_locked_i(sl),
        .xosc_running_i(xrun), .global_irq_en_i(glob), .sync_hdr_i(sh),
        .phy_hdr_ok_i(ph), .frame_len_i(len), .rx_byte_vld_i(bv),
        .rx_byte_i(rb), .mhr_done_i(md), .addr_match_i(am), .rx_end_i(re),
        .fcs_ok_i(fo), .tx_end_i(te), .reg_en_o(reg_en_o),
        .synth_en_o(synth_en_o), .synth_tx_o(synth_tx_o), .rx_en_o(rx_en_o),
        .pa_en_o(pa_en_o), .tx_start_o(tx_start_o), .xosc_en_o(xosc_en_o),
        .ftune_o(ftune_o), .channel_o(channel_o), .fb_we_o(fb_we_o),
        .fb_addr_o(fb_addr_o), .fb_data_o(fb_data_o), .irq_o(irq_o));
    rbsc_fe_model fe_u (.clk_i(clk_i), .rst_i(rst_i), .reg_en_i(reg_en_o),
        .synth_en_i(synth_en_o), .tx_start_i(tx_start_o), .rx_go_i(rx_go),
        .len_i(len), .seed_i(seed), .match_i(match), .fcs_i(fcs),
        .reg_settled_o(rs), .synth_locked_o(sl), .sync_hdr_o(sh),
        .phy_hdr_ok_o(ph), .rx_byte_vld_o(bv), .rx_byte_o(rb),
        .mhr_done_o(md), .addr_match_o(am), .rx_end_o(re), .fcs_ok_o(fo),
        .tx_end_o(te));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] exp_byte(input logic [7:0] s, input int i);
        return s + 8'(i);
    endfunction
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic conclude;
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one classic bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdo;
        check(n < 50, "bus gave no ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e, input string msg);
        wb(1'b0, a, 32'h0);
        check((q & m) === e, msg);
    endtask
    task automatic wait_st(input logic [4:0] e);
        int n;
        n = 0;
        do begin
            wb(1'b0, `RBSC_ADR_STATUS, 32'h0);
            n++;
        end while (q[4:0] !== e && n < 400);
        check(q[4:0] === e, "state not reached");
    endtask
    // clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // frame buffer must get every received byte in order
    always @(posedge clk_i) begin
        if (fb_we_o === 1'b1) begin
            check(fb_data_o === exp_byte(seed, fb_n), "frame byte");
            fb_n = fb_n + 1;
        end
        if (synth_en_o === 1'b1 && reg_en_o !== 1'b1) begin
            check(1'b0, "synth on before regulator");
        end
        if (ftune_o === 1'b1) begin
            ftseen = 1'b1;
        end
    end
    // watchdog
    initial begin
        repeat (30000) @(posedge clk_i);
        bad_count++;
        conclude();
    end
    // main sequence
    initial begin
        {cyc, stb, we, glob, xrun, adc, rx_go, match, fcs} = '0;
        adr = 8'h00;
        wdat = 32'h0;
        sel = 4'hF;
        len = 7'h04;
        seed = 8'h00;
        rnd = 16'h0012;
        fb_n = 0;
        ftseen = 1'b0;
        rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_rd(`RBSC_ADR_STATUS, 32'h1F, 32'h08, "reset state");
        check(channel_o === `RBSC_CHAN_RST && reg_en_o === 1'b0, "reset out");
        chk_rd(8'h1C, 32'hFFFFFFFF, 32'h0, "unmapped read");
        rnd = lfsr(rnd);
        ch = rnd[4:0];
        wb(1'b1, `RBSC_ADR_CHANNEL, {27'h0, ch});
        check(channel_o === ch, "channel");
        wb(1'b1, `RBSC_ADR_MASK, 32'hFF);
        glob <= 1'b1;
        wb(1'b1, `RBSC_ADR_COMMAND, {27'h0, `RBSC_CMD_SYNTH});
        chk_rd(`RBSC_ADR_STATUS, 32'h1F, 32'h1F, "pending code");
        wait_st(`RBSC_ST_SYNTH_RDY);
        repeat (60) @(posedge clk_i);
        chk_rd(`RBSC_ADR_FLAGS, 32'h01, 32'h01, "lock flag");
        check(irq_o === 1'b1, "irq with enables");
        glob <= 1'b0;
        repeat (3) @(posedge clk_i);
        check(irq_o === 1'b0, "irq without global");
        glob <= 1'b1;
        wb(1'b1, `RBSC_ADR_FLAGS, 32'hFF);
        wb(1'b1, `RBSC_ADR_COMMAND, {27'h0, `RBSC_CMD_LISTEN});
        chk_rd(`RBSC_ADR_STATUS, 32'h1F, 32'h06, "listen at once");
        check(rx_en_o === 1'b1, "receiver on");
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            len <= 7'd4 + 7'(rnd[6:0] % 100);
            seed <= rnd[15:8];
            match <= rnd[2];
            fcs <= rnd[3];
            fb_n = 0;
            rx_go <= 1'b1;
            @(posedge clk_i);
            rx_go <= 1'b0;
            repeat (6) @(posedge clk_i);
            chk_rd(`RBSC_ADR_STATUS, 32'h1F, 32'h01, "busy rx");
            check(rx_en_o === 1'b1, "receiver held");
            wait_st(`RBSC_ST_LISTEN);
            check(fb_n == len, "byte count");
            chk_rd(`RBSC_ADR_FLAGS, 32'h2C, {26'h0, match, 5'h0C}, "rx flags");
            chk_rd(`RBSC_ADR_RSSI, 32'h80, {24'h0, fcs, 7'h0}, "fcs bit");
            wb(1'b1, `RBSC_ADR_FLAGS, 32'hFF);
        end
        repeat (200) @(posedge clk_i);
        chk_rd(`RBSC_ADR_STATUS, 32'h1F, 32'h06, "listen kept");
        adc <= 1'b1;
        wb(1'b1, `RBSC_ADR_COMMAND, {27'h0, `RBSC_CMD_SYNTH});
        wait_st(`RBSC_ST_SYNTH_RDY);
        for (int m = 0; m < 3; m++) begin
            rnd = lfsr(rnd);
            len <= (m == 2) ? 7'h00 : 7'd4 + 7'(rnd[5:0]);
            if (m == 1) begin
                wb(1'b1, `RBSC_ADR_PIN, 32'h1);
            end else begin
                wb(1'b1, `RBSC_ADR_COMMAND, {27'h0, `RBSC_CMD_TX_GO});
            end
            t = 0;
            while (tx_start_o !== 1'b1 && t < 400 && m != 2) begin
                @(posedge clk_i);
                t++;
            end
            check(m == 2 || (t >= 318 && t <= 322), "first chip delay");
            check(m == 2 || (pa_en_o & synth_tx_o) === 1'b1, "tx path on");
            if (m == 1) begin
                wb(1'b1, `RBSC_ADR_PIN, 32'h0);
            end
            wait_st(`RBSC_ST_SYNTH_RDY);
            check(pa_en_o === 1'b0, "amplifier off");
            chk_rd(`RBSC_ADR_FLAGS, 32'h40, (m == 2) ? 32'h0 : 32'h40, "tx done");
            wb(1'b1, `RBSC_ADR_FLAGS, 32'hFF);
        end
        wb(1'b1, `RBSC_ADR_COMMAND, {27'h0, `RBSC_CMD_IDLE});
        wait_st(`RBSC_ST_CLK_IDLE);
        for (int w = 0; w < 2; w++) begin
            xrun <= w[0];
            wb(1'b1, `RBSC_ADR_PIN, 32'h1);
            wait_st(`RBSC_ST_SLEEP);
            ftseen = 1'b0;
            t0 = $realtime;
            wb(1'b1, `RBSC_ADR_PIN, 32'h0);
            wait_st(`RBSC_ST_CLK_IDLE);
            t = int'(($realtime - t0) / 50.0);
            check(t >= ((w == 0) ? 20 : 500), "wake too early");
            check(t <= ((w == 0) ? 32 : 512), "wake too late");
            check(ftseen === 1'b1, "filter tuning");
            chk_rd(`RBSC_ADR_FLAGS, 32'h80, 32'h80, "wake flag");
            wb(1'b1, `RBSC_ADR_FLAGS, 32'hFF);
        end
        wb(1'b1, `RBSC_ADR_COMMAND, {27'h0, `RBSC_CMD_LISTEN});
        wb(1'b1, `RBSC_ADR_PIN, 32'h2);
        chk_rd(`RBSC_ADR_STATUS, 32'h1F, 32'h08, "radio reset state");
        chk_rd(`RBSC_ADR_MASK, 32'hFF, 32'h0, "radio reset mask");
        conclude();
    end
endmodule // radio_basic_state_control_tb

// >>> sim/rbsc_fe_model.sv
`timescale 1ns/100ps
// analog front end and frame source facing the state controller
module rbsc_fe_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reg_en_i,
    input wire logic synth_en_i,
    input wire logic tx_start_i,
    input wire logic rx_go_i,
    input wire logic [6:0] len_i,
    input wire logic [7:0] seed_i,
    input wire logic match_i,
    input wire logic fcs_i,
    output logic reg_settled_o,
    output logic synth_locked_o,
    output logic sync_hdr_o,
    output logic phy_hdr_ok_o,
    output logic rx_byte_vld_o,
    output logic [7:0] rx_byte_o,
    output logic mhr_done_o,
    output logic addr_match_o,
    output logic rx_end_o,
    output logic fcs_ok_o,
    output logic tx_end_o
);
    int reg_cnt = 0;
    int syn_cnt = 0;
    int rx_cnt = 0;
    int tx_cnt = 0;
    logic in_byte;
    int last;
    assign in_byte = rx_cnt >= 5 && rx_cnt < 5 + 2 * len_i && rx_cnt[0];
    assign last = 6 + 2 * len_i;
    // settling is slow, so the state controller has to wait for it
    always @(posedge clk_i) begin
        reg_cnt <= (rst_i || !reg_en_i) ? 0 : reg_cnt + 1;
        syn_cnt <= (rst_i || !synth_en_i) ? 0 : syn_cnt + 1;
        reg_settled_o <= reg_cnt > 30;
        synth_locked_o <= syn_cnt > 40;
    end
    // frame: sync, header, a byte every other cycle, then frame end
    always @(posedge clk_i) begin
        sync_hdr_o <= rx_cnt == 1;
        phy_hdr_ok_o <= rx_cnt == 3;
        rx_byte_vld_o <= in_byte;
        rx_byte_o <= in_byte ? seed_i + 8'((rx_cnt - 5) / 2) : ~rx_byte_o;
        mhr_done_o <= rx_cnt == 12;
        addr_match_o <= match_i;
        rx_end_o <= rx_cnt == last;
        fcs_ok_o <= fcs_i;
        tx_end_o <= tx_cnt == 8 + len_i && len_i != 7'h00;
        if (rst_i || rx_go_i) begin
            rx_cnt <= rst_i ? 0 : 1;
        end else begin
            rx_cnt <= (rx_cnt != 0 && rx_cnt < last) ? rx_cnt + 1 : 0;
        end
        if (rst_i || tx_start_i) begin
            tx_cnt <= rst_i ? 0 : 1;
        end else begin
            tx_cnt <= (tx_cnt != 0 && tx_cnt < 8 + len_i) ? tx_cnt + 1 : 0;
        end
    end
endmodule // rbsc_fe_model
